// file: include/aeis_pkg.sv
// Constants, register map and types for the alarm and error interrupt status block
//--------------------------------------------------------------------------------
//--------------------------------------------------------------------------------
package aeis_pkg;

    // Register byte offsets
    localparam logic [7:0] AEIS_OFS_BLOCK_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] AEIS_OFS_STAT = 8'h04;
    localparam logic [7:0] AEIS_OFS_MASK = 8'h08;
    localparam logic [7:0] AEIS_OFS_FCTL = 8'h0C;
    localparam logic [7:0] AEIS_OFS_PEND = 8'h10;

    // Field positions
    localparam int AEIS_BLOCK_INTERRUPT_ENABLE_FRAMER = 0;
    localparam int AEIS_BLOCK_INTERRUPT_ENABLE_ALARM = 1;
    localparam int AEIS_ST_OOF = 7;
    localparam int AEIS_ST_AIS = 6;
    localparam int AEIS_ST_MYEL = 5;
    localparam int AEIS_ST_LOS = 4;
    localparam int AEIS_THR_MSB = 2;

    // Reset values
    localparam logic [7:0] AEIS_BLOCK_INTERRUPT_ENABLE_RST = 8'h00;
    localparam logic [7:0] AEIS_MASK_RST = 8'h00;
    localparam logic [2:0] AEIS_THR_RST = 3'h0;

    // Line timing: one E1 frame lasts 125 us
    localparam int AEIS_FRAME_US = 125;
    localparam int AEIS_AIS_US = 250;
    localparam int AEIS_AIS_FRAMES = AEIS_AIS_US / AEIS_FRAME_US;
    localparam int AEIS_AIS_ZERO_MAX = 2;
    localparam int AEIS_LOS_BITS = 175;
    localparam int AEIS_LOS_DENS_DIV = 8;

    // Bus slave states
    typedef enum logic [1:0] {
        AEIS_IDLE = 2'b01,
        AEIS_WAIT = 2'b10
    } aeis_bus_t;

endpackage : aeis_pkg

// file: design/aeis_top.sv
// Alarm and error interrupt status block with AHB-Lite register slave
`timescale 1ns/1ps

module aeis_top
    import aeis_pkg::*;
#(
    parameter int LOS_BITS = AEIS_LOS_BITS,
    parameter int AIS_FRAMES = AEIS_AIS_FRAMES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RX_BIT_STB,
    input wire logic RX_BIT,
    input wire logic FRAME_STB,
    input wire logic FAS_STB,
    input wire logic FAS_ERR,
    input wire logic MF_Y_STB,
    input wire logic MF_Y_BIT,
    input wire logic LOS_COND,
    input wire logic FRAMER_IRQ_REQ,
    output logic IRQ
);

    //----------------------------------------------------------------
    // Declarations
    //----------------------------------------------------------------
    aeis_bus_t bus_r;
    logic [7:0] addr_r;
    logic write_r;
    logic [7:0] block_interrupt_enable_r;
    logic [7:0] mask_r;
    logic [2:0] thr_r;
    logic oof_r;
    logic [2:0] fas_cnt_r;
    logic ais_r;
    logic [1:0] zero_cnt_r;
    logic [1:0] ones_run_r;
    logic [1:0] clear_run_r;
    logic myel_r;
    logic myel_ev_r;
    logic los_r;
    logic [7:0] los_run_r;
    logic [7:0] win_cnt_r;
    logic [7:0] win_ones_r;
    logic irq_nxt;
    logic rd_stat;
    logic myel_ev_nxt;
    logic accept;
    logic [7:0] stat_val;
    logic [7:0] pend_val;
    logic alarm_pend;
    logic framer_pend;

    // Value of a register as seen by a read
    function automatic logic [7:0] reg_read(
        input logic [7:0] ofs,
        input logic [7:0] stat,
        input logic [7:0] pend
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (ofs)
            AEIS_OFS_BLOCK_INTERRUPT_ENABLE: v = block_interrupt_enable_r;
            AEIS_OFS_STAT: v = stat;
            AEIS_OFS_MASK: v = mask_r;
            AEIS_OFS_FCTL: v = {5'h00, thr_r};
            AEIS_OFS_PEND: v = pend;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    //----------------------------------------------------------------
    // AHB-Lite slave: every accepted word transfer takes one wait state
    //----------------------------------------------------------------

    // Address phase accepted only for word transfers
    assign accept = HSEL && HTRANS[1] && HREADY && (HSIZE == 3'b010);

    // Bus state, latched address and response
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_r <= AEIS_IDLE;
            addr_r <= 8'h00;
            write_r <= 1'b0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            unique case (bus_r)
                AEIS_IDLE: begin
                    if (accept) begin
                        bus_r <= AEIS_WAIT;
                        addr_r <= HADDR[7:0];
                        write_r <= HWRITE;
                        HREADYOUT <= 1'b0;
                    end
                end
                AEIS_WAIT: begin
                    bus_r <= AEIS_IDLE;
                    HREADYOUT <= 1'b1;
                end
            endcase
        end
    end

    // Read data captured in the wait cycle, zero for unmapped offsets
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_r == AEIS_WAIT && !write_r) begin
            HRDATA <= {24'h00_0000, reg_read(addr_r, stat_val, pend_val)};
        end
    end

    // A read of the status register clears its latched bit
    assign rd_stat = (bus_r == AEIS_WAIT) && !write_r && (addr_r == AEIS_OFS_STAT);

    // Software writes to control registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            block_interrupt_enable_r <= AEIS_BLOCK_INTERRUPT_ENABLE_RST;
            mask_r <= AEIS_MASK_RST;
            thr_r <= AEIS_THR_RST;
        end else if (bus_r == AEIS_WAIT && write_r) begin
            if (addr_r == AEIS_OFS_BLOCK_INTERRUPT_ENABLE) begin
                block_interrupt_enable_r <= HWDATA[7:0];
            end
            if (addr_r == AEIS_OFS_MASK) begin
                mask_r <= HWDATA[7:0];
            end
            if (addr_r == AEIS_OFS_FCTL) begin
                thr_r <= HWDATA[AEIS_THR_MSB:0];
            end
        end
    end

    //----------------------------------------------------------------
    // Out-of-frame detection
    //----------------------------------------------------------------

    // Count consecutive errored alignment patterns against the threshold
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fas_cnt_r <= 3'h0;
            oof_r <= 1'b0;
        end else if (FAS_STB) begin
            if (FAS_ERR) begin
                if (fas_cnt_r != 3'h7) begin
                    fas_cnt_r <= fas_cnt_r + 3'h1;
                end
                if ({1'b0, fas_cnt_r} + 4'h1 >= {1'b0, thr_r}) begin
                    oof_r <= 1'b1;
                end
            end else begin
                fas_cnt_r <= 3'h0;
                oof_r <= 1'b0;
            end
        end
    end

    //----------------------------------------------------------------
    // AIS detection, judged once per frame
    //----------------------------------------------------------------

    // Zeros seen in the current frame, saturating above the limit
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            zero_cnt_r <= 2'h0;
        end else if (FRAME_STB) begin
            zero_cnt_r <= (RX_BIT_STB && !RX_BIT) ? 2'h1 : 2'h0;
        end else if (RX_BIT_STB && !RX_BIT && zero_cnt_r != 2'h3) begin
            zero_cnt_r <= zero_cnt_r + 2'h1;
        end
    end

    // Consecutive frames with at most two zeros and consecutive frames with more
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ones_run_r <= 2'h0;
            clear_run_r <= 2'h0;
            ais_r <= 1'b0;
        end else if (FRAME_STB) begin
            if (32'(zero_cnt_r) <= AEIS_AIS_ZERO_MAX) begin
                clear_run_r <= 2'h0;
                if (32'(ones_run_r) + 1 >= AIS_FRAMES) begin
                    ais_r <= 1'b1;
                end else begin
                    ones_run_r <= ones_run_r + 2'h1;
                end
            end else begin
                ones_run_r <= 2'h0;
                if (32'(clear_run_r) + 1 >= AIS_FRAMES) begin
                    ais_r <= 1'b0;
                end else begin
                    clear_run_r <= clear_run_r + 2'h1;
                end
            end
        end
    end

    //----------------------------------------------------------------
    // Multiframe yellow alarm and its change event
    //----------------------------------------------------------------

    // Change in either direction raises the event
    assign myel_ev_nxt = MF_Y_STB && (MF_Y_BIT != myel_r);

    // Alarm follows the y bit of timeslot 16, frame 0
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            myel_r <= 1'b0;
        end else if (MF_Y_STB) begin
            myel_r <= MF_Y_BIT;
        end
    end

    // Sticky event bit; a new event wins over the read clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            myel_ev_r <= 1'b0;
        end else begin
            myel_ev_r <= myel_ev_nxt || (myel_ev_r && !rd_stat);
        end
    end

    //----------------------------------------------------------------
    // Loss of signal detection
    //----------------------------------------------------------------

    // Run length of the condition and the density window
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            los_run_r <= 8'h00;
            win_cnt_r <= 8'h00;
            win_ones_r <= 8'h00;
            los_r <= 1'b0;
        end else if (RX_BIT_STB) begin
            if (!LOS_COND) begin
                los_run_r <= 8'h00;
                los_r <= 1'b0;
            end else if (32'(los_run_r) + 1 >= LOS_BITS) begin
                los_r <= 1'b1;
            end else begin
                los_run_r <= los_run_r + 8'h01;
            end
            if (32'(win_cnt_r) + 1 >= LOS_BITS) begin
                win_cnt_r <= 8'h00;
                win_ones_r <= 8'h00;
                if ((32'(win_ones_r) + 32'(RX_BIT)) * AEIS_LOS_DENS_DIV >= LOS_BITS) begin
                    los_r <= 1'b0;
                    los_run_r <= 8'h00;
                end
            end else begin
                win_cnt_r <= win_cnt_r + 8'h01;
                win_ones_r <= win_ones_r + {7'h00, RX_BIT};
            end
        end
    end

    //----------------------------------------------------------------
    // Status view and interrupt gating
    //----------------------------------------------------------------

    // Live defect states plus the latched event
    always_comb begin
        stat_val = 8'h00;
        stat_val[AEIS_ST_OOF] = oof_r;
        stat_val[AEIS_ST_AIS] = ais_r;
        stat_val[AEIS_ST_MYEL] = myel_ev_r;
        stat_val[AEIS_ST_LOS] = los_r;
    end

    // Source gates, then block gates
    assign alarm_pend = |(stat_val & mask_r & 8'h20) && block_interrupt_enable_r[AEIS_BLOCK_INTERRUPT_ENABLE_ALARM];
    assign framer_pend = FRAMER_IRQ_REQ && block_interrupt_enable_r[AEIS_BLOCK_INTERRUPT_ENABLE_FRAMER];

    // Alarm bit of the block pending summary drops once the event is read away
    always_comb begin
        pend_val = 8'h00;
        pend_val[AEIS_BLOCK_INTERRUPT_ENABLE_ALARM] = alarm_pend;
        pend_val[AEIS_BLOCK_INTERRUPT_ENABLE_FRAMER] = framer_pend;
    end

    assign irq_nxt = alarm_pend || framer_pend;

    // Registered interrupt output
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_nxt;
        end
    end

endmodule : aeis_top

// file: testbench/aeis_assertions.sv
// Port-level checks for the alarm and error interrupt status block
`timescale 1ns/1ps
module aeis_assertions
    import aeis_pkg::*;
#(
    parameter int LOS_BITS = AEIS_LOS_BITS,
    parameter int AIS_FRAMES = AEIS_AIS_FRAMES
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic MF_Y_STB,
    input wire logic MF_Y_BIT,
    input wire logic FRAMER_IRQ_REQ,
    input wire logic IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic y_last_r;
    logic myel_r;
    logic rd_r;
    logic done_r;
    logic [7:0] ofs_r;
    logic take;
    // Accepted word transfer
    assign take = HSEL && HTRANS[1] && HREADY && (HSIZE == 3'b010) && HREADYOUT;
    // Shadow of the transfer in flight and of the latched yellow change
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            y_last_r <= 1'b0;
            myel_r <= 1'b0;
            rd_r <= 1'b0;
            done_r <= 1'b0;
            ofs_r <= 8'h00;
        end else begin
            if (take) begin
                rd_r <= !HWRITE;
                ofs_r <= HADDR[7:0];
            end
            if (MF_Y_STB) begin
                y_last_r <= MF_Y_BIT;
            end
            done_r <= !HREADYOUT;
            myel_r <= (MF_Y_STB && (MF_Y_BIT != y_last_r)) ||
                      (myel_r && !(!HREADYOUT && rd_r && ofs_r == AEIS_OFS_STAT));
        end
    end
    property p_rdy_pulse;
        !HREADYOUT |=> HREADYOUT;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("wait state too long");
    property p_rdy_take;
        take |=> !HREADYOUT;
    endproperty
    a_rdy_take: assert property (p_rdy_take) else $error("transfer not answered");
    property p_resp;
        !HRESP;
    endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
    property p_rd_upper;
        done_r && rd_r |-> HRDATA[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_stat_rd;
        done_r && rd_r && ofs_r == AEIS_OFS_STAT |-> HRDATA[5] == $past(myel_r);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("yellow event bit wrong");
    property p_unmapped;
        done_r && rd_r && ofs_r > AEIS_OFS_PEND |-> HRDATA == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold;
        HREADYOUT |=> $stable(HRDATA);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_irq_cause;
        IRQ |-> $past(FRAMER_IRQ_REQ) || $past(myel_r);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule : aeis_assertions

// file: testbench/aeis_line_model.sv
// Behavioural receive framer feeding line events into the block
`timescale 1ns/1ps
module aeis_line_model (
    input wire logic clk,
    output logic rx_bit_stb,
    output logic rx_bit,
    output logic frame_stb,
    output logic fas_stb,
    output logic fas_err,
    output logic mf_y_stb,
    output logic mf_y_bit,
    output logic los_cond
);
    // Quiet line at time zero
    initial begin
        {rx_bit_stb, rx_bit, frame_stb, fas_stb, fas_err, mf_y_stb, mf_y_bit, los_cond} = 8'h00;
    end
    // Bits with leading zeros; released data shows the inverse
    task automatic bits(input int n, input int zeros, input logic los, input logic frm);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_bit_stb <= 1'b1;
            rx_bit <= (i >= zeros);
            frame_stb <= frm && (i == 0);
            los_cond <= los;
            @(posedge clk);
            rx_bit_stb <= 1'b0;
            frame_stb <= 1'b0;
            rx_bit <= (i < zeros);
        end
    endtask : bits
    // One alignment check
    task automatic fas(input logic err);
        @(posedge clk);
        fas_stb <= 1'b1;
        fas_err <= err;
        @(posedge clk);
        fas_stb <= 1'b0;
        fas_err <= !err;
    endtask : fas
    // Remote alarm y bit of the signalling slot
    task automatic ybit(input logic v);
        @(posedge clk);
        mf_y_stb <= 1'b1;
        mf_y_bit <= v;
        @(posedge clk);
        mf_y_stb <= 1'b0;
        mf_y_bit <= !v;
    endtask : ybit
endmodule : aeis_line_model

// file: testbench/tb_top.sv
// Self-checking bench for the alarm and error interrupt status block
`timescale 1ns/1ps
module tb_top
    import aeis_pkg::*;
    ;
    localparam int LOSN = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic req = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic rx_stb, rx_bit, frm_stb, fas_stb, fas_err, y_stb, y_bit, los;
    logic [7:0] ofs [6] = '{AEIS_OFS_BLOCK_INTERRUPT_ENABLE, AEIS_OFS_STAT, AEIS_OFS_MASK, AEIS_OFS_FCTL, AEIS_OFS_PEND, 8'h14};
    int n_fail = 0;
    int check_count = 0;
    // Clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    aeis_top #(.LOS_BITS(LOSN)) dut_u (
        .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .RX_BIT_STB(rx_stb), .RX_BIT(rx_bit), .FRAME_STB(frm_stb), .FAS_STB(fas_stb),
        .FAS_ERR(fas_err), .MF_Y_STB(y_stb), .MF_Y_BIT(y_bit), .LOS_COND(los), .FRAMER_IRQ_REQ(req),
        .IRQ(irq)
    );
    aeis_line_model line_u (
        .clk(clk), .rx_bit_stb(rx_stb), .rx_bit(rx_bit), .frame_stb(frm_stb), .fas_stb(fas_stb),
        .fas_err(fas_err), .mf_y_stb(y_stb), .mf_y_bit(y_bit), .los_cond(los)
    );
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Single word transfer; entered just after a clock edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, a, d, t);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] t;
        ahb(1'b0, a, 32'h0000_0000, t);
        check(t, exp);
        check(32'(hresp), 32'h0000_0000);
    endtask : rdc
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'(v));
    endtask : irq_is
    task automatic frames(input int n, input int zeros);
        repeat (n) line_u.bits(16, zeros, 1'b0, 1'b1);
    endtask : frames
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // Watchdog
    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (ofs[i]) rdc(ofs[i], 32'h0000_0000);
        wr(8'h14, 32'h0000_00FF);
        rdc(8'h14, 32'h0000_0000);
        // A byte-sized write is ignored, so the source enable stays off
        hsize <= 3'b000;
        wr(AEIS_OFS_MASK, 32'h0000_0020);
        hsize <= 3'b010;
        rdc(AEIS_OFS_MASK, 32'h0000_0000);
        wr(AEIS_OFS_MASK, 32'h0000_0020);
        line_u.ybit(1'b1);
        irq_is(1'b0);
        wr(AEIS_OFS_BLOCK_INTERRUPT_ENABLE, 32'h0000_0002);
        irq_is(1'b1);
        rdc(AEIS_OFS_PEND, 32'h0000_0002);
        wr(AEIS_OFS_MASK, 32'h0000_0000);
        irq_is(1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0020);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        rdc(AEIS_OFS_PEND, 32'h0000_0000);
        wr(AEIS_OFS_MASK, 32'h0000_0020);
        line_u.ybit(1'b1);
        irq_is(1'b0);
        line_u.ybit(1'b0);
        irq_is(1'b1);
        rdc(AEIS_OFS_STAT, 32'h0000_0020);
        irq_is(1'b0);
        req <= 1'b1;
        wr(AEIS_OFS_BLOCK_INTERRUPT_ENABLE, 32'h0000_0000);
        irq_is(1'b0);
        wr(AEIS_OFS_BLOCK_INTERRUPT_ENABLE, 32'h0000_0001);
        irq_is(1'b1);
        rdc(AEIS_OFS_BLOCK_INTERRUPT_ENABLE, 32'h0000_0001);
        req <= 1'b0;
        irq_is(1'b0);
        wr(AEIS_OFS_FCTL, 32'h0000_0003);
        rdc(AEIS_OFS_FCTL, 32'h0000_0003);
        repeat (2) line_u.fas(1'b1);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        line_u.fas(1'b1);
        rdc(AEIS_OFS_STAT, 32'h0000_0080);
        line_u.fas(1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        frames(1, 0);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        frames(2, 0);
        rdc(AEIS_OFS_STAT, 32'h0000_0040);
        frames(1, 3);
        rdc(AEIS_OFS_STAT, 32'h0000_0040);
        frames(2, 3);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        frames(3, 2);
        rdc(AEIS_OFS_STAT, 32'h0000_0040);
        frames(3, 3);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        line_u.bits(LOSN - 1, LOSN, 1'b1, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        line_u.bits(1, 1, 1'b1, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0010);
        // Ones density over a full window clears loss of signal
        line_u.bits(LOSN - 1, 0, 1'b1, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0010);
        line_u.bits(1, 0, 1'b1, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        // Re-arm, then clear by the condition going away
        line_u.bits(LOSN, LOSN, 1'b1, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0010);
        line_u.bits(1, 1, 1'b0, 1'b0);
        rdc(AEIS_OFS_STAT, 32'h0000_0000);
        stop_test();
    end
endmodule : tb_top

bind aeis_top aeis_assertions #(.LOS_BITS(LOS_BITS), .AIS_FRAMES(AIS_FRAMES)) chk_u (
    .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MF_Y_STB(MF_Y_STB),
    .MF_Y_BIT(MF_Y_BIT), .FRAMER_IRQ_REQ(FRAMER_IRQ_REQ), .IRQ(IRQ)
);
